// ===== uart_shadow_pkg.sv
// shared constants and carriers for the uart shadow buffer block
// assumes a 32-bit apb master and byte-wide serial character streams
package uart_shadow_pkg;

  // ==========================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [31:0] SHADOW_BASE   = 32'h5000_1030;
  localparam logic [31:0] SHADOW_5_ADDR = 32'h5000_1044;
  localparam logic [31:0] SHADOW_6_ADDR = 32'h5000_1048;
  localparam logic [31:0] SHADOW_STRIDE = 32'h0000_0004;
  localparam logic [31:0] SHADOW_COUNT  = 32'h0000_0010;
  localparam logic [31:0] CTRL_ADDR     = 32'h5000_1080;
  localparam logic [31:0] STATUS_ADDR   = 32'h5000_1084;

  // ==========================================================
  // field positions and reset values
  localparam int          CTRL_FIFO_EN_BIT = 0;
  localparam int          CTRL_IR_BIT      = 1;
  localparam int          STAT_DR_BIT      = 0;
  localparam int          STAT_OVR_BIT     = 1;
  localparam int          STAT_TX_HOLDING_EMPTY_FLAG_BIT    = 5;
  localparam logic [1:0]  CTRL_RESET       = 2'h0;
  localparam logic [7:0]  DATA_RESET       = 8'h00;

  // ==========================================================
  // sizes
  localparam int          DATA_W     = 8;
  localparam int          FIFO_DEPTH = 16;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } char_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_t;

endpackage

// ===== uart_shadow_buffer.sv
// shadow receive buffer / transmit holding path of a uart, apb slave
// assumes receiver and transmitter shifters outside, one char per pulse
//
// Operation
// - sixteen consecutive 32-bit shadow words alias receive and transmit
// - shadow read low byte gives char from serial or infrared input
// - received byte valid only while data-ready flag is set
// - fifos off: unread byte overwritten by next char, overrun flagged
// - fifos on: shadow read returns head of receive fifo
// - receive fifo full: keep entries, drop new char, flag overrun
// - shadow write low byte loads char for serial or infrared output
// - fifos off: single write clears the holding-empty flag
// - fifos off: further writes before flag sets overwrite pending char
// - fifos on: accepts fifo-depth writes, sixteen, before full
// - write while transmit fifo full is discarded, contents unchanged
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps

// ============================================================
// synchronous fifo
module sync_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         flush,
  // fill side
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn || flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= bump(wr_q);
      if (pop) rd_q <= bump(rd_q);
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// ============================================================
// shadow buffer top
module uart_shadow_buffer (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  // apb slave
  input  wire uart_shadow_pkg::apb_req_t apb_req,
  output      uart_shadow_pkg::apb_rsp_t apb_rsp,
  // receive characters from the shifters
  input  wire uart_shadow_pkg::char_t    rx_uart,
  input  wire uart_shadow_pkg::char_t    rx_ir,
  output      logic                      rx_ready,
  // transmit characters to the shifters
  output      uart_shadow_pkg::char_t    tx_uart,
  input  wire logic                      tx_uart_ready,
  output      uart_shadow_pkg::char_t    tx_ir,
  input  wire logic                      tx_ir_ready
);
  import uart_shadow_pkg::*;

  // ==========================================================
  // address decode
  localparam logic [31:0] SHADOW_END = SHADOW_BASE
                                     + SHADOW_STRIDE * SHADOW_COUNT;

  function automatic logic in_shadow(input logic [31:0] a);
    in_shadow = (a >= SHADOW_BASE) && (a < SHADOW_END)
             && (a[1:0] == 2'h0);
  endfunction

  wire acc      = apb_req.psel & apb_req.penable;
  wire sh_hit   = in_shadow(apb_req.paddr);
  wire ctrl_hit = (apb_req.paddr == CTRL_ADDR);
  wire stat_hit = (apb_req.paddr == STATUS_ADDR);
  wire sh_rd    = acc & ~apb_req.pwrite & sh_hit;
  wire sh_wr    = acc & apb_req.pwrite & sh_hit;
  wire ctrl_wr  = acc & apb_req.pwrite & ctrl_hit;
  wire stat_rd  = acc & ~apb_req.pwrite & stat_hit;

  // ==========================================================
  // control
  logic [1:0] ctrl_q;
  wire fifo_en = ctrl_q[CTRL_FIFO_EN_BIT];
  wire ir_mode = ctrl_q[CTRL_IR_BIT];
  wire [1:0] ctrl_new = apb_req.pwdata[1:0];
  // changing fifo mode empties both paths so stale data never crosses
  wire flush = ctrl_wr & (ctrl_new[CTRL_FIFO_EN_BIT] != fifo_en);

  always_ff @(posedge mclk) begin
    if (!rstn) ctrl_q <= CTRL_RESET;
    else if (ctrl_wr) ctrl_q <= ctrl_new;
  end

  // ==========================================================
  // receive path
  char_t             rx_in;
  logic              rxf_in_ready;
  logic              rxf_out_valid;
  logic [DATA_W-1:0] rxf_out_data;
  logic [DATA_W-1:0] rx_hold_q;
  logic              rx_hold_v_q;
  logic              ovr_q;

  assign rx_in = ir_mode ? rx_ir : rx_uart;

  sync_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .flush     (flush),
    .in_valid  (fifo_en & rx_in.valid),
    .in_ready  (rxf_in_ready),
    .in_data   (rx_in.data),
    .out_valid (rxf_out_valid),
    .out_ready (fifo_en & sh_rd),
    .out_data  (rxf_out_data)
  );

  // new char wins over a read in the same cycle; it is the live one
  always_ff @(posedge mclk) begin
    if (!rstn || flush) begin
      rx_hold_q   <= DATA_RESET;
      rx_hold_v_q <= 1'b0;
    end else if (!fifo_en && rx_in.valid) begin
      rx_hold_q   <= rx_in.data;
      rx_hold_v_q <= 1'b1;
    end else if (!fifo_en && sh_rd) begin
      rx_hold_v_q <= 1'b0;
    end
  end

  wire rx_data_ready_flag = fifo_en ? rxf_out_valid : rx_hold_v_q;
  wire [DATA_W-1:0] rx_byte = fifo_en ? rxf_out_data : rx_hold_q;

  wire ovr_set = rx_in.valid & (fifo_en ? ~rxf_in_ready
                                        : rx_hold_v_q & ~sh_rd);

  // set wins over the clear-on-read of the status word
  always_ff @(posedge mclk) begin
    if (!rstn) ovr_q <= 1'b0;
    else if (ovr_set) ovr_q <= 1'b1;
    else if (stat_rd) ovr_q <= 1'b0;
  end

  // advisory only: a char offered while full is still dropped
  assign rx_ready = fifo_en ? rxf_in_ready : 1'b1;

  // ==========================================================
  // transmit path
  logic              txf_in_ready;
  logic              txf_out_valid;
  logic [DATA_W-1:0] txf_out_data;
  logic [DATA_W-1:0] tx_hold_q;
  logic              tx_hold_v_q;

  wire sink_ready = ir_mode ? tx_ir_ready : tx_uart_ready;

  // a write that finds the fifo full is simply not pushed
  sync_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .flush     (flush),
    .in_valid  (fifo_en & sh_wr),
    .in_ready  (txf_in_ready),
    .in_data   (apb_req.pwdata[DATA_W-1:0]),
    .out_valid (txf_out_valid),
    .out_ready (fifo_en & sink_ready),
    .out_data  (txf_out_data)
  );

  wire src_valid = fifo_en ? txf_out_valid : tx_hold_v_q;
  wire [DATA_W-1:0] src_data = fifo_en ? txf_out_data : tx_hold_q;
  wire tx_take = src_valid & sink_ready;

  // write wins over the shifter taking the char in the same cycle
  always_ff @(posedge mclk) begin
    if (!rstn || flush) begin
      tx_hold_q   <= DATA_RESET;
      tx_hold_v_q <= 1'b0;
    end else if (!fifo_en && sh_wr) begin
      tx_hold_q   <= apb_req.pwdata[DATA_W-1:0];
      tx_hold_v_q <= 1'b1;
    end else if (!fifo_en && tx_take) begin
      tx_hold_v_q <= 1'b0;
    end
  end

  // master is trusted to check this before writing
  wire tx_holding_empty_flag = ~src_valid;

  assign tx_uart.valid = src_valid & ~ir_mode;
  assign tx_uart.data  = src_data;
  assign tx_ir.valid   = src_valid & ir_mode;
  assign tx_ir.data    = src_data;

  // ==========================================================
  // read mux and response
  logic [31:0] status_word;
  always_comb begin
    status_word                = 32'h0000_0000;
    status_word[STAT_DR_BIT]   = rx_data_ready_flag;
    status_word[STAT_OVR_BIT]  = ovr_q;
    status_word[STAT_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag;
  end

  wire [31:0] sh_word   = {24'h00_0000, rx_byte};
  wire [31:0] ctrl_word = {30'h0000_0000, ctrl_q};

  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = acc & ~(sh_hit | ctrl_hit | stat_hit);
  assign apb_rsp.prdata  = ~acc | apb_req.pwrite ? 32'h0000_0000 :
                           sh_hit   ? sh_word     :
                           ctrl_hit ? ctrl_word   :
                           stat_hit ? status_word : 32'h0000_0000;
endmodule

// ===== uart_shadow_buffer_props.sv
// port assertions for the uart shadow buffer
// assumes the top ports of uart_shadow_buffer; bound after endmodule
`timescale 1ns/10ps
// ============================================================
// checker
module uart_shadow_buffer_props (
  // clock and reset
  input wire logic                      mclk,
  input wire logic                      rstn,
  // apb
  input wire uart_shadow_pkg::apb_req_t apb_req,
  input wire uart_shadow_pkg::apb_rsp_t apb_rsp,
  // streams
  input wire uart_shadow_pkg::char_t    rx_uart,
  input wire uart_shadow_pkg::char_t    rx_ir,
  input wire logic                      rx_ready,
  input wire uart_shadow_pkg::char_t    tx_uart,
  input wire logic                      tx_uart_ready,
  input wire uart_shadow_pkg::char_t    tx_ir,
  input wire logic                      tx_ir_ready
);
  import uart_shadow_pkg::*;
  logic [31:0] off;
  logic [1:0]  ctrl_q;
  logic        acc, wr, sh, rd_sh, wr_sh, mapped;
  logic [7:0]  last_rx_q;
  logic        rx_pend_q;
  assign acc = apb_req.psel && apb_req.penable;
  assign wr = acc && apb_req.pwrite;
  assign off = apb_req.paddr - SHADOW_BASE;
  assign sh = off < 32'h40 && off[1:0] == 2'h0;
  assign rd_sh = acc && !apb_req.pwrite && sh;
  assign wr_sh = wr && sh;
  assign mapped = sh || apb_req.paddr inside {CTRL_ADDR, STATUS_ADDR};
  // shadow copy of the mode bits, the ports alone do not show them
  always_ff @(posedge mclk) begin
    if (!rstn) ctrl_q <= 2'h0;
    else if (wr && apb_req.paddr == CTRL_ADDR) ctrl_q <= apb_req.pwdata[1:0];
  end
  // last char offered in uart mode with fifos off, and whether it is unread
  // a control write drops the pending mark, as a mode change may flush
  always_ff @(posedge mclk) begin
    if (!rstn || (wr && apb_req.paddr == CTRL_ADDR)) rx_pend_q <= 1'b0;
    else if (rx_uart.valid && ctrl_q == 2'h0) rx_pend_q <= 1'b1;
    else if (rd_sh) rx_pend_q <= 1'b0;
  end
  always_ff @(posedge mclk) begin
    if (rx_uart.valid && ctrl_q == 2'h0) last_rx_q <= rx_uart.data;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_rx_hold;
    rd_sh && ctrl_q == 2'h0 && rx_pend_q;
  endsequence
  AST_PREADY: assert property (acc |-> apb_rsp.pready)
    else $error("no ready in access phase");
  AST_UNMAPPED: assert property (acc |-> apb_rsp.pslverr == !mapped)
    else $error("error response does not match decode");
  AST_HI_ZERO: assert property (rd_sh |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("shadow upper bits not zero");
  AST_RX_READ: assert property (s_rx_hold
    |-> apb_rsp.prdata[7:0] == last_rx_q) else $error("rx byte");
  AST_TX_LOAD: assert property (wr_sh && ctrl_q == 2'h0 |=> tx_uart.valid
    && tx_uart.data == $past(apb_req.pwdata[7:0])) else $error("tx load");
  AST_TX_HOLD: assert property (tx_uart.valid && !tx_uart_ready && !wr
    |=> tx_uart.valid && $stable(tx_uart.data)) else $error("tx dropped");
  AST_TX_PORT: assert property (!ctrl_q[1] |-> !tx_ir.valid)
    else $error("infrared output used in uart mode");
  AST_RX_READY: assert property (!ctrl_q[0] |-> rx_ready)
    else $error("rx not ready with fifos off");
endmodule

bind uart_shadow_buffer uart_shadow_buffer_props chk_u (.*);

// ===== uart_shadow_partner.sv
// far-side model: receiver and transmitter shifters of the uart
// assumes the bench calls send and reads got; stall holds ready low
`timescale 1ns/10ps
// ============================================================
// shifter model
module uart_shadow_partner (
  // clock and bench control
  input wire logic                   mclk,
  input wire logic                   ir,
  input wire logic                   stall,
  // characters towards the block
  output uart_shadow_pkg::char_t     rx_uart,
  output uart_shadow_pkg::char_t     rx_ir,
  // characters from the block
  input wire uart_shadow_pkg::char_t tx_uart,
  input wire uart_shadow_pkg::char_t tx_ir,
  output logic                       tx_uart_ready,
  output logic                       tx_ir_ready
);
  import uart_shadow_pkg::*;
  logic [7:0] got[$];
  initial rx_uart = '0;
  initial rx_ir = '0;
  // stall models a slow transmitter
  assign tx_uart_ready = !stall;
  assign tx_ir_ready = !stall;
  // one pulse per char; data inverted once the strobe drops
  task automatic send(input logic [7:0] d);
    @(posedge mclk);
    if (ir) rx_ir <= '{1'b1, d};
    else rx_uart <= '{1'b1, d};
    @(posedge mclk);
    rx_ir <= '{1'b0, ~d};
    rx_uart <= '{1'b0, ~d};
  endtask
  always @(posedge mclk) begin
    if (tx_uart.valid && tx_uart_ready) got.push_back(tx_uart.data);
    if (tx_ir.valid && tx_ir_ready) got.push_back(tx_ir.data);
  end
endmodule

// ===== uart_shadow_buffer_tb_top.sv
// self-checking bench for the uart shadow buffer
// assumes package, partner model and bound checker compiled before
`timescale 1ns/10ps
// ============================================================
// bench top
module uart_shadow_buffer_tb_top;
  import uart_shadow_pkg::*;
  logic        mclk, rstn, rx_ready, stall, ir, serr;
  logic        tx_uart_ready, tx_ir_ready;
  logic [31:0] r;
  apb_req_t    apb_req;
  apb_rsp_t    apb_rsp;
  char_t       rx_uart, rx_ir, tx_uart, tx_ir;
  int          errors, n_tests;
  uart_shadow_buffer dut_u (.*);
  uart_shadow_partner part_u (.*);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ============================================================
  // bus and compare helpers
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge mclk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    do @(posedge mclk); while (apb_rsp.pready !== 1'b1);
    r = apb_rsp.prdata;
    serr = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [31:0] a, e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic results;
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ============================================================
  // scenarios
  task automatic t_reset;
    rd(STATUS_ADDR, 32'h20);
    rd(SHADOW_5_ADDR, 32'h0);
    rd(SHADOW_BASE + 32'h41, 32'h0);
    chk({31'h0, serr}, 32'h1);
  endtask
  task automatic t_tx_off;
    stall <= 1'b1;
    // first write once the holding-empty flag is seen set, second while it is seen clear
    rd(STATUS_ADDR, 32'h20);
    apb(1'b1, SHADOW_5_ADDR, 32'h41);
    rd(STATUS_ADDR, 32'h0);
    apb(1'b1, SHADOW_6_ADDR, 32'hff42);
    stall <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(part_u.got.size(), 32'h1);
    chk(part_u.got.pop_front(), 32'h42);
  endtask
  task automatic t_rx_off;
    part_u.send(8'h11);
    rd(STATUS_ADDR, 32'h21);
    rd(SHADOW_BASE, 32'h11);
    part_u.send(8'h12);
    part_u.send(8'h13);
    rd(STATUS_ADDR, 32'h23);
    rd(SHADOW_BASE + 32'h3c, 32'h13);
    rd(STATUS_ADDR, 32'h20);
  endtask
  task automatic t_ir;
    ir <= 1'b1;
    apb(1'b1, CTRL_ADDR, 32'h2);
    part_u.send(8'h5a);
    rd(SHADOW_6_ADDR, 32'h5a);
    apb(1'b1, SHADOW_5_ADDR, 32'ha5);
    repeat (3) @(posedge mclk);
    chk(part_u.got.pop_front(), 32'ha5);
    ir <= 1'b0;
  endtask
  // seventeenth write must be lost while the fifo is full
  task automatic t_fifo_tx;
    apb(1'b1, CTRL_ADDR, 32'h1);
    stall <= 1'b1;
    for (int i = 0; i < 17; i++) apb(1'b1, SHADOW_BASE + 32'(4 * (i % 16)), i);
    rd(STATUS_ADDR, 32'h0);
    stall <= 1'b0;
    repeat (20) @(posedge mclk);
    chk(part_u.got.size(), 32'd16);
    for (int i = 0; i < 16; i++) chk(part_u.got.pop_front(), i);
  endtask
  task automatic t_fifo_rx;
    for (int i = 0; i < 17; i++) part_u.send(8'h40 + 8'(i));
    rd(STATUS_ADDR, 32'h23);
    chk({31'h0, rx_ready}, 32'h0);
    for (int i = 0; i < 16; i++) rd(SHADOW_BASE + 32'(4 * i), 32'h40 + i);
    rd(STATUS_ADDR, 32'h20);
    chk({31'h0, rx_ready}, 32'h1);
  endtask
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    results();
  end
  initial begin
    rstn = 1'b0;
    stall = 1'b0;
    ir = 1'b0;
    apb_req = '0;
    errors = 0;
    n_tests = 0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_tx_off();
    t_rx_off();
    t_ir();
    t_fifo_tx();
    t_fifo_rx();
    results();
  end
endmodule
